// *** tb/fepc_chk_monitor.sv ***
// assertions on the flash access controller ports
`default_nettype none
module fepc_chk #(
    parameter int REGIONS = 16,
    parameter int UNIT_WORDS = 256
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // requests
    input wire logic rdReq,
    input wire logic pgmReq,
    input wire logic eraseReq,
    input wire logic [1:0] rdSrc,
    input wire logic [12:0] rdAddr,
    input wire logic [12:0] pgmAddr,
    input wire logic [4:0] eraseUnit,
    input wire logic [2*REGIONS-1:0] protCfg,
    // answers
    input wire logic rdValid,
    input wire logic rdErr,
    input wire logic eraseBusy,
    input wire logic wrErr,
    input wire logic [31:0] rdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // unit sweep plus the hand-back cycle
    localparam int ERASE_CYCLES = UNIT_WORDS + 1;
    logic [9:0] busyCnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt <= 10'h0;
        end else begin
            busyCnt <= eraseBusy ? busyCnt + 10'h1 : 10'h0;
        end
    end
    wire [1:0] rdP = protCfg[2*rdAddr[12:9] +: 2];
    wire [1:0] pgP = protCfg[2*pgmAddr[12:9] +: 2];
    wire [1:0] erP = protCfg[2*eraseUnit[4:1] +: 2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence erOk; eraseReq && !eraseBusy && erP == 2'h0; endsequence
    sequence erDone; $fell(eraseBusy); endsequence
    erase_len_a: assert property (erDone |-> busyCnt == ERASE_CYCLES) else $error("erase length wrong");
    ro_read_a: assert property (rdReq && rdP == 2'h1 |=> rdValid) else $error("ro read refused");
    rd_answer_a: assert property (rdReq |=> rdValid != rdErr) else $error("read unanswered");
    rd_quiet_a: assert property (!rdReq |=> !rdValid && !rdErr) else $error("stray read answer");
    xo_deny_a: assert property (rdReq && rdSrc != 2'h0 && rdP == 2'h2 |=> rdErr) else $error("xo read");
    fetch_ok_a: assert property (rdReq && rdSrc == 2'h0 |=> rdValid) else $error("fetch refused");
    ro_refuse_a: assert property (pgmReq && !eraseReq && !eraseBusy && pgP == 2'h1 |=> wrErr)
        else $error("ro program taken");
    xo_erase_a: assert property (eraseReq && !eraseBusy && erP == 2'h2 |=> wrErr) else $error("xo erase");
    erase_go_a: assert property (erOk |=> eraseBusy && !wrErr) else $error("erase not started");
    err_data_a: assert property (rdErr |-> rdData == 32'h0) else $error("refused read leaks data");
    wr_quiet_a: assert property (!pgmReq && !eraseReq |=> !wrErr) else $error("stray wrErr");
endmodule
`default_nettype wire

// *** tb/fepc_host.sv ***
// requester model on the read port
`default_nettype none
module fepc_host (
    // clock
    input wire logic ref_clk,
    // read request
    output var logic rdReq,
    output var logic [1:0] rdSrc,
    output var logic [12:0] rdAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rdReq, rdSrc, rdAddr} = 16'h0;
    task rd(input logic [1:0] s, input logic [12:0] a);
        @(negedge ref_clk) {rdReq, rdSrc, rdAddr} = {1'b1, s, a};
        @(negedge ref_clk) {rdReq, rdSrc, rdAddr} = {1'b0, ~s, ~a};
    endtask
endmodule
`default_nettype wire

// *** tb/fepc_top_tb.sv ***
// self-checking bench for the flash access controller
`default_nettype none
module fepc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, pgmReq = 0, eraseReq = 0, rdReq, rdValid, rdErr, eraseBusy, wrErr;
    logic [1:0] rdSrc, s;
    logic [12:0] rdAddr, a, pgmAddr = 0;
    logic [4:0] eraseUnit = 0;
    logic [31:0] pgmData = 0, protCfg = 0, rdData, d;
    int nFail, checkCount, cyc, k;
    initial forever #2 ref_clk = ~ref_clk;
    fepc_host host_u (.ref_clk(ref_clk), .rdReq(rdReq), .rdSrc(rdSrc), .rdAddr(rdAddr));
    fepc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .rdReq(rdReq), .rdSrc(rdSrc), .rdAddr(rdAddr),
        .rdValid(rdValid), .rdData(rdData), .rdErr(rdErr), .pgmReq(pgmReq), .pgmAddr(pgmAddr),
        .pgmData(pgmData), .eraseReq(eraseReq), .eraseUnit(eraseUnit), .eraseBusy(eraseBusy),
        .wrErr(wrErr), .protCfg(protCfg));
    function logic [31:0] ex(input logic [12:0] x); return x == 13'h1ab ? d : 32'hffffffff; endfunction
    task chk(input logic [33:0] g, e, input string n);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task rdT(input logic [1:0] sr, input logic [12:0] x, input logic [31:0] e, input logic er);
        host_u.rd(sr, x);
        chk({rdErr, rdValid, rdData}, {er, !er, e}, "read");
    endtask
    task wr(input logic er, input logic [12:0] x, input logic e);
        @(negedge ref_clk) {eraseReq, pgmReq, pgmAddr, eraseUnit, pgmData} = {er, !er, x, x[12:8], d};
        @(negedge ref_clk) {eraseReq, pgmReq} = 2'h0;
        chk(wrErr, e, "wrErr");
        for (k = 0; k < 300 && eraseBusy; k++) @(negedge ref_clk);
        chk(eraseBusy, 0, "eraseBusy");
    endtask
    task wrapUp;
        $display("checks %0d failures %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc == 3000) begin
        nFail++;
        wrapUp;
    end
    initial begin
        d = $urandom(32'hb58d81ff);
        repeat (4) @(negedge ref_clk);
        rst_n = 1;
        wr(1, 0, 0);
        wr(1, 13'h100, 0);
        wr(0, 13'h1ab, 0);
        wr(1, 0, 0);
        rdT(1, 13'h1ab, d, 0);
        rdT(2, 13'h0ff, 32'hffffffff, 0);
        $display("erase test done");
        protCfg = 32'h1;
        wr(0, 13'h0, 1);
        wr(1, 13'h100, 1);
        rdT(1, 13'h0, 32'hffffffff, 0);
        protCfg = 32'h2;
        wr(0, 13'h1ab, 1);
        wr(1, 13'h100, 1);
        wr(0, 13'h200, 0);
        rdT(0, 13'h1ab, d, 0);
        repeat (12) begin
            a = 13'($urandom % 512);
            s = 2'($urandom % 3);
            rdT(s, a, s == 2'h0 ? ex(a) : 32'h0, s != 2'h0);
        end
        protCfg = 32'h3;
        wr(1, 13'h000, 1);
        rdT(1, 13'h0ff, 32'hffffffff, 0);
        $display("protection test done");
        wrapUp;
    end
endmodule
bind fepc_top fepc_chk #(.REGIONS(REGIONS)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .rdReq(rdReq),
    .pgmReq(pgmReq), .eraseReq(eraseReq), .rdSrc(rdSrc), .rdAddr(rdAddr), .pgmAddr(pgmAddr),
    .eraseUnit(eraseUnit), .protCfg(protCfg), .rdValid(rdValid), .rdErr(rdErr),
    .eraseBusy(eraseBusy), .wrErr(wrErr), .rdData(rdData));
`default_nettype wire

// *** verilog/fepc_array.v ***
// flash word array with a one-unit erase sweep
`default_nettype none
`include "fepc_regs.vh"
module fepc_array #(
    parameter WORD_BITS = `FEPC_WORD_BITS,
    parameter ADDR_BITS = `FEPC_ADDR_BITS,
    parameter UNIT_WORDS = `FEPC_UNIT_WORDS
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // read port
    input wire [ADDR_BITS-1:0] rdAddr,
    output reg [WORD_BITS-1:0] rdData,
    // program port
    input wire wrEn,
    input wire [ADDR_BITS-1:0] wrAddr,
    input wire [WORD_BITS-1:0] wrData,
    // erase port
    input wire eraseStart,
    input wire [ADDR_BITS-9:0] eraseUnit,
    output reg eraseBusy
);
    localparam [31:0] LAST_SWEEP = UNIT_WORDS - 1;
    reg [WORD_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
    reg [`FEPC_SWEEP_BITS-1:0] sweep_r;
    reg [ADDR_BITS-9:0] unit_r;
    wire lastSweep;
    assign lastSweep = (sweep_r == LAST_SWEEP[`FEPC_SWEEP_BITS-1:0]);
    // read is combinational so the owner can register the answer in one cycle
    always @* begin
        rdData = mem[rdAddr];
    end
    always @(posedge ref_clk) begin
        if (eraseBusy) begin
            mem[{unit_r, sweep_r}] <= `FEPC_ERASED_WORD;
        end else if (wrEn) begin
            mem[wrAddr] <= wrData & mem[wrAddr];
        end
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eraseBusy <= 1'b0;
            sweep_r <= {`FEPC_SWEEP_BITS{1'b0}};
            unit_r <= {(ADDR_BITS-`FEPC_SWEEP_BITS){1'b0}};
        end else if (eraseBusy) begin
            sweep_r <= sweep_r + 1'b1;
            if (lastSweep) begin
                eraseBusy <= 1'b0;
            end
        end else if (eraseStart) begin
            eraseBusy <= 1'b1;
            unit_r <= eraseUnit;
            sweep_r <= {`FEPC_SWEEP_BITS{1'b0}};
        end
    end
endmodule
`default_nettype wire

// *** verilog/fepc_regs.vh ***
// constants for the flash erase and protection controller
`ifndef FEPC_REGS_VH
`define FEPC_REGS_VH
`define FEPC_WORD_BITS 32
`define FEPC_ADDR_BITS 13
`define FEPC_UNIT_WORDS 256
`define FEPC_UNIT_BITS 5
`define FEPC_REGION_BITS 4
`define FEPC_ERASED_WORD 32'hffffffff
`define FEPC_PROT_NONE 2'h0
`define FEPC_PROT_RO 2'h1
`define FEPC_PROT_XO 2'h2
`define FEPC_SRC_FETCH 2'h0
`define FEPC_SRC_DATA 2'h1
`define FEPC_SRC_DEBUG 2'h2
`define FEPC_SWEEP_BITS 8
`define FEPC_PROT_BITS 2
`endif

// *** verilog/fepc_top.v ***
// flash access control with per-region protection
// What this block does
// - a 32 KB array is erased in 1 KB units, each alone.
// - an erased unit reads back all ones.
// - protection is held per 2 KB region of two 1 KB units.
// - each region may be set read-only or execute-only.
// - erase and program into a read-only region are refused.
// - erase and program into an execute-only region are refused.
// - execute-only regions answer only instruction fetch reads.
// - allowed reads answer one cycle later with no wait.
`default_nettype none
`include "fepc_regs.vh"
module fepc_top #(
    parameter REGIONS = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // read request
    input wire rdReq,
    input wire [1:0] rdSrc,
    input wire [`FEPC_ADDR_BITS-1:0] rdAddr,
    output reg rdValid,
    output reg [`FEPC_WORD_BITS-1:0] rdData,
    output reg rdErr,
    // program request
    input wire pgmReq,
    input wire [`FEPC_ADDR_BITS-1:0] pgmAddr,
    input wire [`FEPC_WORD_BITS-1:0] pgmData,
    // erase request
    input wire eraseReq,
    input wire [`FEPC_UNIT_BITS-1:0] eraseUnit,
    output reg eraseBusy,
    output reg wrErr,
    // protection settings, two bits per region
    input wire [2*REGIONS-1:0] protCfg
);
    // erase controller states, one hot
    localparam [1:0] ER_IDLE = 2'h1;
    localparam [1:0] ER_SWEEP = 2'h2;

    // protection code of one region out of the packed settings
    function [`FEPC_PROT_BITS-1:0] protOf;
        input [2*REGIONS-1:0] cfg;
        input [`FEPC_REGION_BITS-1:0] region;
        begin
            protOf = cfg[`FEPC_PROT_BITS*region +: `FEPC_PROT_BITS];
        end
    endfunction
    // region index of a word address
    function [`FEPC_REGION_BITS-1:0] regionOfWord;
        input [`FEPC_ADDR_BITS-1:0] addr;
        begin
            regionOfWord = addr[`FEPC_ADDR_BITS-1 -: `FEPC_REGION_BITS];
        end
    endfunction
    // two adjacent erase units share one region
    function [`FEPC_REGION_BITS-1:0] regionOfUnit;
        input [`FEPC_UNIT_BITS-1:0] unit;
        begin
            regionOfUnit = unit[`FEPC_UNIT_BITS-1 -: `FEPC_REGION_BITS];
        end
    endfunction
    // any guarded region refuses program and erase
    function writeDenied;
        input [`FEPC_PROT_BITS-1:0] prot;
        begin
            case (prot)
                `FEPC_PROT_NONE: writeDenied = 1'b0;
                `FEPC_PROT_RO: writeDenied = 1'b1;
                `FEPC_PROT_XO: writeDenied = 1'b1;
                default: writeDenied = 1'b1;
            endcase
        end
    endfunction
    // only instruction fetch may read an execute-only region
    function readDenied;
        input [`FEPC_PROT_BITS-1:0] prot;
        input [1:0] src;
        begin
            case (prot)
                `FEPC_PROT_XO: readDenied = (src != `FEPC_SRC_FETCH);
                default: readDenied = 1'b0;
            endcase
        end
    endfunction

    // array side
    wire arrBusy;
    wire [`FEPC_WORD_BITS-1:0] arrData;
    // decoded protection of each request
    wire [`FEPC_PROT_BITS-1:0] rdProt;
    wire [`FEPC_PROT_BITS-1:0] pgProt;
    wire [`FEPC_PROT_BITS-1:0] erProt;
    wire rdDeny;
    wire pgDeny;
    wire erDeny;
    wire erIdle;
    // accepted program and erase strobes
    reg pgGo;
    reg erGo;
    // erase controller
    reg [1:0] erState_r;
    reg [1:0] erState_nxt;
    // next values of the registered outputs
    reg rdValid_nxt;
    reg rdErr_nxt;
    reg [`FEPC_WORD_BITS-1:0] rdData_nxt;
    reg wrErr_nxt;
    reg eraseBusy_nxt;

    assign rdProt = protOf(protCfg, regionOfWord(rdAddr));
    assign pgProt = protOf(protCfg, regionOfWord(pgmAddr));
    assign erProt = protOf(protCfg, regionOfUnit(eraseUnit));
    assign rdDeny = readDenied(rdProt, rdSrc);
    assign pgDeny = writeDenied(pgProt);
    assign erDeny = writeDenied(erProt);
    assign erIdle = (erState_r == ER_IDLE);

    // erase wins over a program in the same cycle; nothing is taken while busy
    always @* begin
        erGo = 1'b0;
        pgGo = 1'b0;
        if (erIdle) begin
            if (eraseReq) begin
                erGo = !erDeny;
            end else if (pgmReq) begin
                pgGo = !pgDeny;
            end
        end
    end

    fepc_array #(
        .WORD_BITS(`FEPC_WORD_BITS),
        .ADDR_BITS(`FEPC_ADDR_BITS),
        .UNIT_WORDS(`FEPC_UNIT_WORDS)
    ) u_array (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rdAddr(rdAddr),
        .rdData(arrData),
        .wrEn(pgGo),
        .wrAddr(pgmAddr),
        .wrData(pgmData),
        .eraseStart(erGo),
        .eraseUnit(eraseUnit),
        .eraseBusy(arrBusy)
    );

    // busy until the array reports its sweep finished
    always @* begin
        erState_nxt = erState_r;
        case (erState_r)
            ER_IDLE: begin
                if (erGo) begin
                    erState_nxt = ER_SWEEP;
                end
            end
            ER_SWEEP: begin
                if (!arrBusy) begin
                    erState_nxt = ER_IDLE;
                end
            end
            default: begin
                erState_nxt = ER_IDLE;
            end
        endcase
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            erState_r <= ER_IDLE;
        end else begin
            erState_r <= erState_nxt;
        end
    end

    // a refused read carries no array data
    always @* begin
        rdValid_nxt = 1'b0;
        rdErr_nxt = 1'b0;
        rdData_nxt = {`FEPC_WORD_BITS{1'b0}};
        if (rdReq) begin
            if (rdDeny) begin
                rdErr_nxt = 1'b1;
            end else begin
                rdValid_nxt = 1'b1;
                rdData_nxt = arrData;
            end
        end
    end
    // erase decides the refusal when both requests come together
    always @* begin
        wrErr_nxt = 1'b0;
        if (eraseReq) begin
            wrErr_nxt = erDeny;
        end else if (pgmReq) begin
            wrErr_nxt = pgDeny;
        end
        eraseBusy_nxt = (erState_nxt == ER_SWEEP);
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdValid <= 1'b0;
            rdErr <= 1'b0;
            rdData <= {`FEPC_WORD_BITS{1'b0}};
        end else begin
            rdValid <= rdValid_nxt;
            rdErr <= rdErr_nxt;
            rdData <= rdData_nxt;
        end
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrErr <= 1'b0;
            eraseBusy <= 1'b0;
        end else begin
            wrErr <= wrErr_nxt;
            eraseBusy <= eraseBusy_nxt;
        end
    end
endmodule
`default_nettype wire
